// ===== rtl/pfear_pkg.sv
/*
 * shared constants and types of the prime-field arithmetic routines:
 * register offsets, control fields, entry codes, operand slots and the
 * point doubling micro-program.
 * assumes one operand store of sixteen slots: A0-3, B0-3, N0-3, scratch.
 */
package pfear_pkg;

   // ---------------------------------------------------------------
   // datapath sizes
   // ---------------------------------------------------------------
   localparam int DIG_W = 16; // one digit of an operand vector
   localparam int ENTRY_W = 12; // width of a routine entry code

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_ENTRY = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [1:0] OPND_WIN = 2'h1; // paddr[11:10] of operand window

   // control register fields and reset value
   localparam int CTRL_APTR_LSB = 0;
   localparam int CTRL_BPTR_LSB = 2;
   localparam int CTRL_NPTR_LSB = 4;
   localparam int CTRL_SIZE_LSB = 8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0300; // size field 3
   localparam logic [31:0] CTRL_MASK = 32'h0000_0f3f; // writable bits

   // status register bits
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERR = 2;

   // ---------------------------------------------------------------
   // routine entry codes
   // ---------------------------------------------------------------
   localparam logic [ENTRY_W-1:0] ENTRY_DOUBLE = 12'h003;
   localparam logic [ENTRY_W-1:0] ENTRY_MADD = 12'h008;
   localparam logic [ENTRY_W-1:0] ENTRY_MSUB = 12'h009;

   // ---------------------------------------------------------------
   // operand slots: bank in bits 3:2, sub-register in bits 1:0
   // ---------------------------------------------------------------
   localparam logic [1:0] BANK_A = 2'h0;
   localparam logic [1:0] BANK_B = 2'h1;
   localparam logic [1:0] BANK_N = 2'h2;
   localparam logic [3:0] SLOT_A3 = 4'h3;
   localparam logic [3:0] SLOT_B1 = 4'h5;
   localparam logic [3:0] SLOT_B2 = 4'h6;
   localparam logic [3:0] SLOT_B3 = 4'h7;
   localparam logic [3:0] SLOT_N0 = 4'h8;
   localparam logic [3:0] SLOT_T0 = 4'hc;
   localparam logic [3:0] SLOT_T1 = 4'hd;
   localparam logic [3:0] SLOT_T2 = 4'he;
   localparam logic [3:0] SLOT_T3 = 4'hf;
   localparam logic [3:0] SLOT_HOST_LAST = 4'hb; // scratch is not host visible

   localparam logic [4:0] DBL_LAST = 5'h16; // 23 steps, 0 to 22

   typedef enum logic [1:0] {
      PFEAR_OP_ADD,
      PFEAR_OP_SUB,
      PFEAR_OP_MUL
   } pfear_op_t;

   typedef struct packed {
      pfear_op_t op;
      logic [3:0] dst;
      logic [3:0] s1;
      logic [3:0] s2;
   } pfear_uop_t;

   // jacobian doubling with general a; only B1-3 and scratch are written
   function automatic pfear_uop_t pfear_dbl_uop(input logic [4:0] step);
      pfear_uop_t u;
      u = '{PFEAR_OP_ADD, SLOT_T0, SLOT_T0, SLOT_T0};
      case (step)
         5'h00: u = '{PFEAR_OP_MUL, SLOT_T0, SLOT_B3, SLOT_B3}; // z^2
         5'h01: u = '{PFEAR_OP_MUL, SLOT_T0, SLOT_T0, SLOT_T0}; // z^4
         5'h02: u = '{PFEAR_OP_MUL, SLOT_T0, SLOT_A3, SLOT_T0}; // a z^4
         5'h03: u = '{PFEAR_OP_MUL, SLOT_T1, SLOT_B1, SLOT_B1}; // x^2
         5'h04: u = '{PFEAR_OP_ADD, SLOT_T2, SLOT_T1, SLOT_T1};
         5'h05: u = '{PFEAR_OP_ADD, SLOT_T1, SLOT_T2, SLOT_T1}; // 3 x^2
         5'h06: u = '{PFEAR_OP_ADD, SLOT_T0, SLOT_T1, SLOT_T0}; // m
         5'h07: u = '{PFEAR_OP_MUL, SLOT_T1, SLOT_B2, SLOT_B2}; // y^2
         5'h08: u = '{PFEAR_OP_MUL, SLOT_T2, SLOT_B1, SLOT_T1};
         5'h09: u = '{PFEAR_OP_ADD, SLOT_T2, SLOT_T2, SLOT_T2};
         5'h0a: u = '{PFEAR_OP_ADD, SLOT_T2, SLOT_T2, SLOT_T2}; // s
         5'h0b: u = '{PFEAR_OP_MUL, SLOT_T3, SLOT_B2, SLOT_B3}; // y z
         5'h0c: u = '{PFEAR_OP_ADD, SLOT_B3, SLOT_T3, SLOT_T3}; // z3
         5'h0d: u = '{PFEAR_OP_MUL, SLOT_T1, SLOT_T1, SLOT_T1}; // y^4
         5'h0e: u = '{PFEAR_OP_ADD, SLOT_T1, SLOT_T1, SLOT_T1};
         5'h0f: u = '{PFEAR_OP_ADD, SLOT_T1, SLOT_T1, SLOT_T1};
         5'h10: u = '{PFEAR_OP_ADD, SLOT_T1, SLOT_T1, SLOT_T1}; // 8 y^4
         5'h11: u = '{PFEAR_OP_MUL, SLOT_T3, SLOT_T0, SLOT_T0}; // m^2
         5'h12: u = '{PFEAR_OP_SUB, SLOT_T3, SLOT_T3, SLOT_T2};
         5'h13: u = '{PFEAR_OP_SUB, SLOT_B1, SLOT_T3, SLOT_T2}; // x3
         5'h14: u = '{PFEAR_OP_SUB, SLOT_T2, SLOT_T2, SLOT_B1};
         5'h15: u = '{PFEAR_OP_MUL, SLOT_T2, SLOT_T0, SLOT_T2};
         5'h16: u = '{PFEAR_OP_SUB, SLOT_B2, SLOT_T2, SLOT_T1}; // y3
         default: u = '{PFEAR_OP_ADD, SLOT_T0, SLOT_T0, SLOT_T0};
      endcase
      return u;
   endfunction : pfear_dbl_uop

endpackage : pfear_pkg

// ===== rtl/pfear_arith_if.sv
/*
 * carrier between the routine sequencer and its two arithmetic units.
 * assumes a single clock; the sequencer drives operands, units answer.
 */
`timescale 1ns/1ps
interface pfear_arith_if #(parameter int W = 256) ();
   logic [W-1:0] opa; // first operand, masked to the size field
   logic [W-1:0] opb; // second operand
   logic [W-1:0] opn; // modulus
   logic sub; // subtract instead of add
   logic [W-1:0] sum; // add/sub result, combinational
   logic mul_start; // one-cycle start of a product
   logic [15:0] mul_bits; // number of reduction steps
   logic mul_done; // one-cycle product ready
   logic [W-1:0] mul_res; // reduced product, registered

   modport core (output opa, opb, opn, sub, mul_start, mul_bits,
      input sum, mul_done, mul_res);
   modport addsub (input opa, opb, opn, sub, output sum);
   modport mul (input opa, opb, opn, mul_start, mul_bits,
      output mul_done, mul_res);
endinterface : pfear_arith_if

// ===== rtl/pfear_mod_addsub.sv
/*
 * modular adder/subtractor over whole operand vectors.
 * assumes both operands are below the modulus; answers in the same cycle.
 */
`timescale 1ns/1ps
module pfear_mod_addsub import pfear_pkg::*; #(
   parameter int W = 256
) (
   pfear_arith_if.addsub ar
);

   // ---------------------------------------------------------------
   // arithmetic
   // ---------------------------------------------------------------
   logic [W+1:0] s; // raw sum or difference, two guard bits
   logic [W+1:0] t; // corrected value

   // same arithmetic in or out of montgomery form: no mode input
   always_comb begin
      s = '0;
      t = '0;
      ar.sum = '0;
      if (!ar.sub) begin
         s = {2'b00, ar.opa} + {2'b00, ar.opb};
         t = s - {2'b00, ar.opn};
         ar.sum = t[W+1] ? s[W-1:0] : t[W-1:0]; // borrow: sum already below n
      end else begin
         s = {2'b00, ar.opa} - {2'b00, ar.opb};
         t = s + {2'b00, ar.opn};
         ar.sum = (ar.opa > ar.opb) ? s[W-1:0] : t[W-1:0];
      end
   end

endmodule : pfear_mod_addsub

// ===== rtl/pfear_mont_mul.sv
/*
 * bit-serial montgomery product a*b*2^-k mod n, one step per clock.
 * assumes operands below n and n odd; operands are latched at start.
 */
`timescale 1ns/1ps
module pfear_mont_mul import pfear_pkg::*; #(
   parameter int W = 256
) (
   input wire logic pclk,
   input wire logic presetn,
   pfear_arith_if.mul ar
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {MM_IDLE, MM_RUN, MM_FIX} pfear_mm_st_t;
   pfear_mm_st_t st_q, st_d;
   logic [W-1:0] a_q, a_d; // multiplier, shifted right each step
   logic [W-1:0] b_q, b_d;
   logic [W-1:0] n_q, n_d;
   logic [W:0] r_q, r_d; // partial result, stays below 2n
   logic [15:0] cnt_q, cnt_d; // steps left
   logic [W-1:0] res_q, res_d;
   logic done_q, done_d;
   logic [W+1:0] t; // step sum

   assign ar.mul_done = done_q;
   assign ar.mul_res = res_q;

   // next state: one reduction per clock keeps the adder narrow
   always_comb begin
      st_d = st_q;
      a_d = a_q;
      b_d = b_q;
      n_d = n_q;
      r_d = r_q;
      cnt_d = cnt_q;
      res_d = res_q;
      done_d = 1'b0;
      t = '0;
      case (st_q)
         MM_IDLE: begin
            if (ar.mul_start) begin
               a_d = ar.opa;
               b_d = ar.opb;
               n_d = ar.opn;
               r_d = '0;
               cnt_d = ar.mul_bits;
               st_d = MM_RUN;
            end
         end
         MM_RUN: begin
            t = {1'b0, r_q} + (a_q[0] ? {2'b00, b_q} : '0);
            if (t[0]) begin
               t = t + {2'b00, n_q}; // make it even before halving
            end
            r_d = t[W+1:1];
            a_d = a_q >> 1;
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
               st_d = MM_FIX;
            end
         end
         MM_FIX: begin
            res_d = (r_q >= {1'b0, n_q}) ? W'(r_q - {1'b0, n_q}) : r_q[W-1:0];
            done_d = 1'b1;
            st_d = MM_IDLE;
         end
         default: st_d = MM_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= MM_IDLE;
         a_q <= '0;
         b_q <= '0;
         n_q <= '0;
         r_q <= '0;
         cnt_q <= '0;
         res_q <= '0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         a_q <= a_d;
         b_q <= b_d;
         n_q <= n_d;
         r_q <= r_d;
         cnt_q <= cnt_d;
         res_q <= res_d;
         done_q <= done_d;
      end
   end

endmodule : pfear_mont_mul

// ===== rtl/pfear_top.sv
/*
 * public_key_unit prime-field routines: point doubling, modular add and
 * modular subtract over an operand store, with an APB register slave.
 * assumes a single 10 MHz clock, an APB master on the same clock and a
 * point multiply sequencer on the same clock that may call the doubling.
 */
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module pfear_top import pfear_pkg::*; #(
   parameter int DIGITS = 16 // digits per operand, at most 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic seq_dbl_start, // doubling call from point multiply
   output logic routine_done // one-cycle pulse at routine end
);

   localparam int W = DIGITS * DIG_W;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // keeps only the digits that the size field selects
   function automatic logic [W-1:0] size_mask(input logic [3:0] sz);
      logic [W-1:0] m;
      m = '0;
      for (int i = 0; i < DIGITS; i++) begin
         if (i <= int'(sz)) begin
            m[i*DIG_W +: DIG_W] = '1;
         end
      end
      return m;
   endfunction : size_mask

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PF_IDLE, PF_EXEC, PF_MULW} pfear_st_t;
   pfear_st_t st_q, st_d;
   logic [31:0] ctrl_q, ctrl_d; // pointers and size
   logic [ENTRY_W-1:0] entry_q, entry_d; // last code written while idle
   logic [4:0] step_q, step_d; // micro-program step
   logic prog_q, prog_d; // 1: doubling program, 0: single host op
   pfear_uop_t hop_q, hop_d; // host add/sub descriptor
   logic [3:0] nsl_q, nsl_d; // modulus slot of the running routine
   logic done_q, done_d; // sticky completion flag
   logic err_q, err_d; // sticky bad entry or busy start
   logic pulse_q, pulse_d; // drives routine_done
   logic [31:0] rd_q, rd_d; // read data, loaded in setup cycle

   // operand store: A0-3, B0-3, N0-3, then internal scratch
   logic [W-1:0] opnd_q [16];
   logic we; // store write enable
   logic [3:0] widx; // store write slot
   logic [W-1:0] wdata; // store write value

   // decoded bus signals
   logic acc; // access phase
   logic setup; // setup phase
   logic hit_ctrl, hit_entry, hit_status, hit_opnd, hit_any;
   logic [3:0] a_slot; // host operand slot
   logic [3:0] a_dig; // host operand digit
   logic busy;
   logic finish; // last step completes this cycle
   logic start_ok; // host start accepted
   logic [ENTRY_W-1:0] code;
   pfear_uop_t cur; // current micro-op
   logic [W-1:0] mask;

   pfear_arith_if #(.W(W)) ar ();

   pfear_mod_addsub #(.W(W)) u_addsub (
      .ar(ar.addsub)
   );

   pfear_mont_mul #(.W(W)) u_mul (
      .pclk(pclk),
      .presetn(presetn),
      .ar(ar.mul)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign setup = psel && !penable;
   assign acc = psel && penable;
   assign a_slot = paddr[9:6];
   assign a_dig = paddr[5:2];
   assign hit_ctrl = (paddr == OFF_CTRL);
   assign hit_entry = (paddr == OFF_ENTRY);
   assign hit_status = (paddr == OFF_STATUS);
   // scratch slots and digits past DIGITS are unmapped
   assign hit_opnd = (paddr[11:10] == OPND_WIN) && (paddr[1:0] == 2'b00) &&
      (a_slot <= SLOT_HOST_LAST) && (int'(a_dig) < DIGITS);
   assign hit_any = hit_ctrl || hit_entry || hit_status || hit_opnd;
   assign busy = (st_q != PF_IDLE);
   assign code = pwdata[ENTRY_W-1:0];
   // a start while busy is refused and flagged
   assign start_ok = acc && pwrite && hit_entry && !busy;

   // zero wait states; unmapped or busy-time data writes raise an error
   assign pready = 1'b1;
   assign pslverr = acc && (!hit_any || (pwrite && busy && !hit_status));
   assign prdata = rd_q;
   assign routine_done = pulse_q;

   // ---------------------------------------------------------------
   // datapath feed
   // ---------------------------------------------------------------
   assign mask = size_mask(ctrl_q[CTRL_SIZE_LSB +: 4]);
   // doubling reads curve values, point and modulus N0
   assign cur = prog_q ? pfear_dbl_uop(step_q) : hop_q;
   assign ar.opa = opnd_q[cur.s1] & mask;
   assign ar.opb = opnd_q[cur.s2] & mask;
   assign ar.opn = opnd_q[nsl_q] & mask;
   assign ar.sub = (cur.op == PFEAR_OP_SUB);
   // product steps cover the digits the size field selects, so r = 2^(16*(size+1))
   assign ar.mul_bits = 16'((int'(ctrl_q[CTRL_SIZE_LSB +: 4]) + 1) * DIG_W);
   assign ar.mul_start = (st_q == PF_EXEC) && (cur.op == PFEAR_OP_MUL);
   assign finish = ((st_q == PF_EXEC) && (cur.op != PFEAR_OP_MUL)) ||
      ((st_q == PF_MULW) && ar.mul_done) ? (!prog_q || step_q == DBL_LAST) : 1'b0;

   // ---------------------------------------------------------------
   // routine sequencer and registers, next values
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      ctrl_d = ctrl_q;
      entry_d = entry_q;
      step_d = step_q;
      prog_d = prog_q;
      hop_d = hop_q;
      nsl_d = nsl_q;
      done_d = done_q;
      err_d = err_q;
      pulse_d = 1'b0;
      rd_d = rd_q;
      we = 1'b0;
      widx = cur.dst;
      wdata = ar.sum;
      // software writes: ctrl only when idle, status bits write one to clear
      if (acc && pwrite && hit_ctrl && !busy) begin
         ctrl_d = pwdata & CTRL_MASK; // pointers chosen by host
      end
      if (acc && pwrite && hit_status) begin
         if (pwdata[ST_DONE]) begin
            done_d = 1'b0;
         end
         if (pwdata[ST_ERR]) begin
            err_d = 1'b0;
         end
      end
      if (acc && pwrite && hit_entry && busy) begin
         err_d = 1'b1;
      end
      // host operand load, refused while a routine owns the store
      if (acc && pwrite && hit_opnd && !busy) begin
         we = 1'b1;
         widx = a_slot;
         wdata = opnd_q[a_slot];
         wdata[int'(a_dig)*DIG_W +: DIG_W] = pwdata[DIG_W-1:0];
      end
      // read data is captured in setup so it stands during access
      if (setup) begin
         rd_d = '0;
         if (hit_ctrl) begin
            rd_d = ctrl_q;
         end else if (hit_entry) begin
            rd_d[ENTRY_W-1:0] = entry_q;
         end else if (hit_status) begin
            rd_d[ST_BUSY] = busy;
            rd_d[ST_DONE] = done_q;
            rd_d[ST_ERR] = err_q;
         end else if (hit_opnd) begin
            rd_d[DIG_W-1:0] = opnd_q[a_slot][int'(a_dig)*DIG_W +: DIG_W];
         end
      end
      case (st_q)
         PF_IDLE: begin
            if (start_ok) begin
               entry_d = code;
               done_d = 1'b0;
               step_d = '0;
               nsl_d = {BANK_N, ctrl_q[CTRL_NPTR_LSB +: 2]};
               // host op: result lands on the selected B slot
               hop_d.dst = {BANK_B, ctrl_q[CTRL_BPTR_LSB +: 2]};
               hop_d.s1 = {BANK_A, ctrl_q[CTRL_APTR_LSB +: 2]};
               hop_d.s2 = {BANK_B, ctrl_q[CTRL_BPTR_LSB +: 2]};
               if (code == ENTRY_DOUBLE) begin
                  prog_d = 1'b1;
                  nsl_d = SLOT_N0;
                  st_d = PF_EXEC;
               end else if (code == ENTRY_MADD) begin
                  prog_d = 1'b0;
                  hop_d.op = PFEAR_OP_ADD;
                  st_d = PF_EXEC;
               end else if (code == ENTRY_MSUB) begin
                  prog_d = 1'b0;
                  hop_d.op = PFEAR_OP_SUB;
                  st_d = PF_EXEC;
               end else begin
                  err_d = 1'b1; // unknown entry code, nothing runs
               end
            end else if (seq_dbl_start) begin
               prog_d = 1'b1; // same program, called from point multiply
               nsl_d = SLOT_N0;
               step_d = '0;
               done_d = 1'b0;
               st_d = PF_EXEC;
            end
         end
         PF_EXEC: begin
            // add/sub steps of the doubling reuse the host adder
            if (cur.op != PFEAR_OP_MUL) begin
               we = 1'b1; // targets are B1-3 and scratch for doubling, the selected B slot for host ops
               widx = cur.dst;
               wdata = ar.sum;
               step_d = step_q + 5'h01;
               st_d = finish ? PF_IDLE : PF_EXEC;
            end else begin
               st_d = PF_MULW;
            end
         end
         PF_MULW: begin
            if (ar.mul_done) begin
               we = 1'b1;
               widx = cur.dst;
               wdata = ar.mul_res;
               step_d = step_q + 5'h01;
               st_d = finish ? PF_IDLE : PF_EXEC;
            end
         end
         default: st_d = PF_IDLE;
      endcase
      // completion sets after any clear in the same cycle
      if (finish) begin
         done_d = 1'b1;
         pulse_d = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= PF_IDLE;
         ctrl_q <= CTRL_RST;
         entry_q <= '0;
         step_q <= '0;
         prog_q <= 1'b0;
         hop_q <= '{PFEAR_OP_ADD, 4'h0, 4'h0, 4'h0};
         nsl_q <= SLOT_N0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         pulse_q <= 1'b0;
         rd_q <= '0;
      end else begin
         st_q <= st_d;
         ctrl_q <= ctrl_d;
         entry_q <= entry_d;
         step_q <= step_d;
         prog_q <= prog_d;
         hop_q <= hop_d;
         nsl_q <= nsl_d;
         done_q <= done_d;
         err_q <= err_d;
         pulse_q <= pulse_d;
         rd_q <= rd_d;
      end
   end

   // ---------------------------------------------------------------
   // operand store: data only, so no reset; one write port
   // ---------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (we) begin
         opnd_q[widx] <= wdata;
      end
   end

endmodule : pfear_top

// ===== verif/pfear_checker.sv
/* bus and completion checks for the prime-field routine block.
   assumes only the top ports, one clock, reset active low. */
`timescale 1ns/1ps
module pfear_checker import pfear_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic seq_dbl_start,
   input wire logic routine_done
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------
   // sequences: access phase, accepted entry write
   // ----------------------------------------------
   sequence acc_s;
      psel && penable;
   endsequence
   sequence entry_s(logic [11:0] c);
      acc_s ##0 (pwrite && paddr == OFF_ENTRY && pwdata[11:0] == c && !pslverr);
   endsequence
   pready_up_a: assert property (acc_s |-> pready) else $error("pready low");
   err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   scratch_err_a: assert property (acc_s ##0 (paddr[11:10] == OPND_WIN && paddr[9:8] == 2'h3)
      |-> pslverr) else $error("scratch slot not refused");
   ctrl_read_a: assert property (acc_s ##0 (!pwrite && paddr == OFF_CTRL) |-> !pslverr)
      else $error("control read refused");
   done_pulse_a: assert property (routine_done |=> !routine_done)
      else $error("done longer than one cycle");
   add_done_a: assert property (entry_s(ENTRY_MADD) |-> ##1 !routine_done ##1 routine_done)
      else $error("add completion late");
   sub_done_a: assert property (entry_s(ENTRY_MSUB) |-> ##1 !routine_done ##1 routine_done)
      else $error("subtract completion late");
   digit_hi_a: assert property (acc_s ##0 (!pwrite && paddr[11:10] == OPND_WIN && !pslverr)
      |-> prdata[31:16] == 16'h0) else $error("operand upper bits set");
endmodule : pfear_checker
bind pfear_top pfear_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .seq_dbl_start(seq_dbl_start),
   .routine_done(routine_done));

// ===== verif/pfear_host_model.sv
/* host processor model: an apb master that moves one word per transfer.
   assumes the caller starts a transfer from clocked context. */
`timescale 1ns/1ps
module pfear_host_model (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // one transfer; an idle edge first so strobes are never set twice in a step
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : pfear_host_model

// ===== verif/tb_top.sv
/* self-checking bench: host model drives apb, a monitor scores each access.
   assumes the design answers every access without wait states. */
`timescale 1ns/1ps
module tb_top import pfear_pkg::*; ;
   logic pclk = 1'b0, presetn = 1'b0, seq_dbl_start = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, routine_done;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [33:0] exp_q[$]; // {err, ignore data, data}
   int n_fail = 0, n_compared = 0;
   logic [63:0] a, b, n, e;
   always #50 pclk = ~pclk;
   pfear_top #(.DIGITS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .seq_dbl_start(seq_dbl_start),
      .routine_done(routine_done));
   pfear_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready));
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
      n_compared++;
      if (x !== y) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", s, x, y);
      end
   endtask : chk
   // monitor: every access takes the oldest note
   always @(posedge pclk) begin
      logic [33:0] t;
      if (psel && penable && pready && exp_q.size() > 0) begin
         t = exp_q.pop_front();
         chk("pslverr", {31'h0, t[33]}, {31'h0, pslverr});
         if (!pwrite && !t[32]) chk("prdata", t[31:0], prdata);
      end
   end
   function automatic logic [11:0] oa(input int s, input int i);
      return 12'h400 + 12'(s) * 12'h40 + 12'(i) * 12'h4;
   endfunction : oa
   task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic er = 1'b0);
      exp_q.push_back({er, 1'b1, 32'h0});
      host.xfer(1'b1, ad, d);
   endtask : wr
   task automatic rd(input logic [11:0] ad, input logic [31:0] d, input logic er = 1'b0);
      exp_q.push_back({er, er, d});
      host.xfer(1'b0, ad, 32'h0);
   endtask : rd
   task automatic wrv(input int s, input logic [63:0] v);
      for (int i = 0; i < 4; i++) wr(oa(s, i), {16'h0, v[16*i+:16]});
   endtask : wrv
   task automatic rdv(input int s, input logic [63:0] v);
      for (int i = 0; i < 4; i++) rd(oa(s, i), {16'h0, v[16*i+:16]});
   endtask : rdv
   task automatic wdone;
      int k;
      k = 0;
      do begin @(posedge pclk); #1; k++; end while (routine_done !== 1'b1 && k < 3000);
      chk("routine_done", 32'h1, {31'h0, routine_done});
   endtask : wdone
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   initial begin
      #2000000;
      n_fail++;
      $display("unexpected watchdog expected done seen hang");
      end_sim();
   end
   initial begin
      int ap, bp, np;
      void'($urandom(15291));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFF_CTRL, CTRL_RST);
      rd(oa(12, 0), 32'h0, 1'b1);
      for (int k = 0; k < 8; k++) begin // add and subtract, random pointers
         ap = $urandom % 4;
         bp = $urandom % 4;
         np = $urandom % 4;
         n = {1'b1, 31'($urandom), 32'($urandom)} | 64'h1;
         a = {32'($urandom), 32'($urandom)} % n;
         b = (k >= 6) ? a : {32'($urandom), 32'($urandom)} % n; // equal operands, both ops
         wrv(ap, a);
         wrv(4 + bp, b);
         wrv(8 + np, n);
         wr(OFF_CTRL, 32'h300 | 32'(np << 4 | bp << 2 | ap));
         wr(OFF_ENTRY, {20'h0, k[0] ? ENTRY_MSUB : ENTRY_MADD});
         wdone();
         e = k[0] ? (a > b ? a - b : a - b + n) : ((65'(a) + b) % n);
         rdv(4 + bp, e);
      end
      $display("test add/sub done");
      n = {1'b1, 31'($urandom), 32'($urandom)} | 64'h1;
      a = {32'($urandom), 32'($urandom)} % n;
      b = {32'($urandom), 32'($urandom)} % n;
      wrv(8, n);
      wrv(0, a);
      wrv(3, b);
      wrv(4, a ^ b);
      wrv(5, b);
      wrv(6, a);
      wrv(7, 64'h0); // z of zero: doubled z stays zero
      @(posedge pclk);
      seq_dbl_start <= 1'b1;
      @(posedge pclk);
      seq_dbl_start <= 1'b0;
      wr(OFF_ENTRY, {20'h0, ENTRY_MADD}, 1'b1); // refused while busy
      wr(OFF_CTRL, 32'h300, 1'b1);
      wdone();
      rdv(0, a);
      rdv(3, b);
      rdv(4, a ^ b);
      rdv(7, 64'h0);
      wr(OFF_ENTRY, {20'h0, ENTRY_DOUBLE});
      wdone();
      rdv(0, a);
      rdv(7, 64'h0);
      $display("test doubling done");
      rd(OFF_STATUS, (32'h1 << ST_DONE) | (32'h1 << ST_ERR));
      rd(OFF_ENTRY, {20'h0, ENTRY_DOUBLE});
      wr(OFF_STATUS, (32'h1 << ST_DONE) | (32'h1 << ST_ERR));
      wr(OFF_ENTRY, 32'h0ff); // unknown code: nothing runs, error flag set
      rd(OFF_STATUS, 32'h1 << ST_ERR);
      $display("test status done");
      end_sim();
   end
endmodule : tb_top
